// ### rtl/tvi_defs.svh
// constants for the two-level vectored interrupt handler
`ifndef TVI_DEFS_SVH
`define TVI_DEFS_SVH
`define TVI_NSRC 23
`define TVI_IDXW 5
`define TVI_VEC_BASE 16'h0003
`define TVI_VEC_SHIFT 3
`define TVI_RESET_VEC 16'h0000
`define TVI_CALL_LAST 3'h4
`define TVI_GEN_BIT 7
`define TVI_MAIN_EN_W 7
`define TVI_HWCLR_MASK 23'h00000f
`define TVI_RO_MASK 23'h008000
`define TVI_RO_SRC 15
`define TVI_A_EN 8'h00
`define TVI_A_XEN 8'h04
`define TVI_A_PRI 8'h08
`define TVI_A_FLA 8'h0c
`define TVI_A_FLB 8'h10
`define TVI_A_STAT 8'h14
`endif

// ### rtl/tvi_pkg.sv
// types shared by the interrupt handler
`include "tvi_defs.svh"
package tvi_pkg;
	typedef enum logic [1:0] {TVI_IDLE = 2'b00, TVI_CALL = 2'b01} tvi_state_e;
	typedef struct packed {
		logic [`TVI_NSRC-1:0] flag_a;
		logic [`TVI_NSRC-1:0] flag_b;
		logic [`TVI_NSRC-1:0] en;
		logic gen;
		logic [`TVI_NSRC-1:0] pri;
		logic ins_hi;
		logic ins_lo;
		logic win_v;
		logic win_hi;
		logic [`TVI_IDXW-1:0] win_idx;
		tvi_state_e st;
		logic [2:0] cnt;
		logic vcall;
		logic [15:0] vaddr;
		logic ack;
		logic [31:0] rdat;
	} tvi_state_s;
endpackage

// ### rtl/tvi_irq_handler.sv
// two-level vectored interrupt handler with a classic wishbone register port
`timescale 1ns/1ns
`include "tvi_defs.svh"

// Function
// - each source sets its pending flag on its event, whatever the enables
// - a request needs pending flag, own enable and global enable together
// - every source has its own enable bit in the enable registers
// - global enable bit 7 of the main enable register overrides all sources
// - flags set while globally disabled stay pending and are served later
// - accepted request waits for instruction end, then long call to vector
// - return instruction ends the current service level and resumes code
// - flags of sources 0 to 3 clear on vectoring; others stay for software
// - flag still set after return makes a new request at once
// - software setting a flag acts like a hardware event, but a vectoring clear in the same cycle wins over it
// - one priority bit per source; high preempts low, nothing preempts high
// - priority bits reset to the low level
// - simultaneous requests: higher level wins, then smallest order number
// - requests decoded every cycle; detect one cycle, call takes five
// - after a return, one more instruction runs before the vector call
// - worst case response is nineteen cycles, return then divide
// - equal or lower level waits until the routine returns plus one instruction
// - vectors 0x0003 plus 8 per order number; reset vector 0x0000
// - any of a source's several flags requests its single vector
// - supply warning flags are read only; only the enable stops them
module tvi_irq_handler
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// peripheral events, one-cycle pulses, first and second flag per source
	input wire logic [`TVI_NSRC-1:0] src_evt_a_i,
	input wire logic [`TVI_NSRC-1:0] src_evt_b_i,
	// supply monitor warning levels, same clock domain
	input wire logic warn_vdd_i,
	input wire logic warn_vbat_i,
	// cpu sequencer
	input wire logic instr_end_i,
	input wire logic return_from_irq_instr_end_i,
	output logic irq_req_o,
	output logic vec_call_o,
	output logic [15:0] vec_addr_o,
	output logic [1:0] in_service_o
);

	// ****************************************
	// state and combinational helpers
	// ****************************************
	tvi_pkg::tvi_state_s s_r;
	tvi_pkg::tvi_state_s s_nxt;
	logic [`TVI_NSRC-1:0] pend;
	logic [`TVI_NSRC-1:0] elig;
	logic [31:0] wmask;
	logic bus_wr;
	logic accept;
	logic [`TVI_NSRC-1:0] hw_clr;

	// byte enables widened to a bit mask
	function automatic logic [31:0] sel_mask(input logic [3:0] sel);
		logic [31:0] m;
		m = 32'h0;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
			begin
				m[b*8 +: 8] = 8'hff;
			end
		end
		return m;
	endfunction

	// ****************************************
	// per-source pending and eligibility
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < `TVI_NSRC; g++)
		begin : g_src
			if (g == `TVI_RO_SRC)
			begin : g_ro
				// warning flags follow the monitor and cannot be cleared
				assign pend[g] = warn_vdd_i | warn_vbat_i;
			end
			else
			begin : g_rw
				assign pend[g] = s_r.flag_a[g] | s_r.flag_b[g];
			end
			// level gate: no request below or at the running level
			assign elig[g] = pend[g] & s_r.en[g] & s_r.gen & ~s_r.ins_hi
				& (~s_r.ins_lo | s_r.pri[g]);
		end
	endgenerate

	// a write lands on the edge where the master sees ack
	assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & s_r.ack;
	assign wmask = sel_mask(wb_sel_i);
	// the boundary of the return instruction itself never vectors
	assign accept = s_r.win_v & instr_end_i & ~return_from_irq_instr_end_i
		& (s_r.st == tvi_pkg::TVI_IDLE);
	assign hw_clr = accept ? (`TVI_HWCLR_MASK & (23'h1 << s_r.win_idx)) : 23'h0;

	// ****************************************
	// next-state logic
	// ****************************************
	// one process builds the whole next state
	always_comb
	begin
		logic found;
		logic [`TVI_NSRC-1:0] fa;
		logic [`TVI_NSRC-1:0] fb;
		logic [31:0] rd;
		found = 1'b0;
		fa = s_r.flag_a;
		fb = s_r.flag_b;
		rd = 32'h0;
		s_nxt = s_r;
		s_nxt.vcall = 1'b0;
		// register writes, byte lane by byte lane
		if (bus_wr)
		begin
			case (wb_adr_i)
				`TVI_A_EN:
				begin
					s_nxt.en[`TVI_MAIN_EN_W-1:0] = (s_r.en[`TVI_MAIN_EN_W-1:0]
						& ~wmask[`TVI_MAIN_EN_W-1:0])
						| (wb_dat_i[`TVI_MAIN_EN_W-1:0] & wmask[`TVI_MAIN_EN_W-1:0]);
					if (wmask[`TVI_GEN_BIT])
					begin
						s_nxt.gen = wb_dat_i[`TVI_GEN_BIT];
					end
				end
				`TVI_A_XEN:
				begin
					s_nxt.en[`TVI_NSRC-1:`TVI_MAIN_EN_W] = (s_r.en[`TVI_NSRC-1:`TVI_MAIN_EN_W]
						& ~wmask[`TVI_NSRC-`TVI_MAIN_EN_W-1:0])
						| (wb_dat_i[`TVI_NSRC-`TVI_MAIN_EN_W-1:0]
						& wmask[`TVI_NSRC-`TVI_MAIN_EN_W-1:0]);
				end
				`TVI_A_PRI:
				begin
					s_nxt.pri = (s_r.pri & ~wmask[`TVI_NSRC-1:0])
						| (wb_dat_i[`TVI_NSRC-1:0] & wmask[`TVI_NSRC-1:0]);
				end
				`TVI_A_FLA:
				begin
					fa = (fa & ~wmask[`TVI_NSRC-1:0])
						| (wb_dat_i[`TVI_NSRC-1:0] & wmask[`TVI_NSRC-1:0]);
				end
				`TVI_A_FLB:
				begin
					fb = (fb & ~wmask[`TVI_NSRC-1:0])
						| (wb_dat_i[`TVI_NSRC-1:0] & wmask[`TVI_NSRC-1:0]);
				end
				default:
				begin
					s_nxt.gen = s_r.gen;
				end
			endcase
		end
		// clears first, then events on top: a coincident event is never lost
		fa = (fa & ~hw_clr) | src_evt_a_i;
		fb = (fb & ~hw_clr) | src_evt_b_i;
		s_nxt.flag_a = fa & ~`TVI_RO_MASK;
		s_nxt.flag_b = fb & ~`TVI_RO_MASK;
		// priority decode every cycle: high level first, lowest order number
		s_nxt.win_v = 1'b0;
		s_nxt.win_hi = 1'b0;
		s_nxt.win_idx = '0;
		for (int i = 0; i < `TVI_NSRC; i++)
		begin
			if (!found && elig[i] && s_r.pri[i])
			begin
				found = 1'b1;
				s_nxt.win_v = 1'b1;
				s_nxt.win_hi = 1'b1;
				s_nxt.win_idx = i[`TVI_IDXW-1:0];
			end
		end
		for (int i = 0; i < `TVI_NSRC; i++)
		begin
			if (!found && elig[i])
			begin
				found = 1'b1;
				s_nxt.win_v = 1'b1;
				s_nxt.win_idx = i[`TVI_IDXW-1:0];
			end
		end
		// return ends the highest level in service
		if (return_from_irq_instr_end_i)
		begin
			if (s_r.ins_hi)
			begin
				s_nxt.ins_hi = 1'b0;
			end
			else
			begin
				s_nxt.ins_lo = 1'b0;
			end
		end
		// call sequencing: the cpu is busy for the five call cycles
		case (s_r.st)
			tvi_pkg::TVI_IDLE:
			begin
				if (accept)
				begin
					s_nxt.st = tvi_pkg::TVI_CALL;
					s_nxt.cnt = 3'h0;
					s_nxt.vcall = 1'b1;
					s_nxt.vaddr = `TVI_VEC_BASE
						+ {8'h0, s_r.win_idx, 3'h0};
					if (s_r.win_hi)
					begin
						s_nxt.ins_hi = 1'b1;
					end
					else
					begin
						s_nxt.ins_lo = 1'b1;
					end
				end
			end
			tvi_pkg::TVI_CALL:
			begin
				s_nxt.cnt = s_r.cnt + 3'h1;
				if (s_r.cnt == `TVI_CALL_LAST)
				begin
					s_nxt.st = tvi_pkg::TVI_IDLE;
				end
			end
			default:
			begin
				s_nxt.st = tvi_pkg::TVI_IDLE;
			end
		endcase
		// read mux; unmapped words read zero
		case (wb_adr_i)
			`TVI_A_EN: rd = {24'h0, s_r.gen, s_r.en[`TVI_MAIN_EN_W-1:0]};
			`TVI_A_XEN: rd = {16'h0, s_r.en[`TVI_NSRC-1:`TVI_MAIN_EN_W]};
			`TVI_A_PRI: rd = {9'h0, s_r.pri};
			`TVI_A_FLA: rd = {9'h0, (s_r.flag_a & ~`TVI_RO_MASK) | (warn_vdd_i ? `TVI_RO_MASK : 23'h0)};
			`TVI_A_FLB: rd = {9'h0, (s_r.flag_b & ~`TVI_RO_MASK) | (warn_vbat_i ? `TVI_RO_MASK : 23'h0)};
			`TVI_A_STAT: rd = {16'h0, 3'h0, s_r.win_idx, 4'h0, s_r.win_v, s_r.st == tvi_pkg::TVI_CALL,
				s_r.ins_hi, s_r.ins_lo};
			default: rd = 32'h0;
		endcase
		// single-wait-state ack, dropped the cycle after
		s_nxt.ack = wb_cyc_i & wb_stb_i & ~s_r.ack;
		s_nxt.rdat = (wb_cyc_i & wb_stb_i & ~s_r.ack) ? rd : s_r.rdat;
	end

	// ****************************************
	// state register
	// ****************************************
	// everything resets to idle, disabled, low priority
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_r <= '0;
			s_r.vaddr <= `TVI_RESET_VEC;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign wb_dat_o = s_r.rdat;
	assign wb_ack_o = s_r.ack;
	assign irq_req_o = s_r.win_v;
	assign vec_call_o = s_r.vcall;
	assign vec_addr_o = s_r.vaddr;
	assign in_service_o = {s_r.ins_hi, s_r.ins_lo};

	// ****************************************
	// assertions
	// ****************************************
	sequence s_call_quiet;
		!vec_call_o [*5];
	endsequence

	sequence s_call_issued;
		vec_call_o && (in_service_o != 2'b00);
	endsequence

	AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (rst_i)
		(|src_evt_a_i) |=> ((s_r.flag_a & $past(src_evt_a_i) & ~`TVI_RO_MASK)
		== ($past(src_evt_a_i) & ~`TVI_RO_MASK)))
		else $error("event did not set its flag");

	AST_GEN_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_req_o |-> $past(s_r.gen))
		else $error("request raised while globally disabled");

	AST_HI_NO_PREEMPT: assert property (@(posedge clk_i) disable iff (rst_i)
		s_r.ins_hi |=> !irq_req_o)
		else $error("request raised during high level routine");

	AST_RETURN_FROM_IRQ_INSTR_SKIP: assert property (@(posedge clk_i) disable iff (rst_i)
		return_from_irq_instr_end_i |=> !vec_call_o)
		else $error("vector call at the return boundary");

	AST_VEC_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_call_o |-> (vec_addr_o == `TVI_VEC_BASE + {8'h0, $past(s_r.win_idx), 3'h0}))
		else $error("wrong vector address");

	AST_CALL_GAP: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_call_o |=> s_call_quiet)
		else $error("second call inside the five call cycles");

	AST_HW_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_call_o |-> ((s_r.flag_a & `TVI_HWCLR_MASK & ~$past(src_evt_a_i)
		& (23'h1 << $past(s_r.win_idx))) == 23'h0))
		else $error("auto-clear flag still set after vectoring");

	AST_INS_SET: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_call_o |-> s_call_issued)
		else $error("vector call without in-service record");

	// the second flag of a source is latched the same way as the first
	AST_FLAG_B_SET: assert property (@(posedge clk_i) disable iff (rst_i)
		(|src_evt_b_i) |=> ((s_r.flag_b & $past(src_evt_b_i) & ~`TVI_RO_MASK)
		== ($past(src_evt_b_i) & ~`TVI_RO_MASK)))
		else $error("second flag event did not set its flag");

	// first edge after reset: nothing in service, nothing asked, low level everywhere
	sequence s_reset_quiet;
		(vec_addr_o == `TVI_RESET_VEC) && (in_service_o == 2'b00) && !irq_req_o
			&& !vec_call_o && (s_r.pri == '0);
	endsequence

	AST_RESET_STATE: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> s_reset_quiet)
		else $error("outputs not idle after reset");

	// a call only follows a registered request
	AST_CALL_NEEDS_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_call_o |-> $past(irq_req_o))
		else $error("vector call without a request");

	// calls start only on an ordinary instruction boundary
	AST_CALL_AT_END: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_call_o |-> ($past(instr_end_i) && !$past(return_from_irq_instr_end_i)))
		else $error("vector call off an instruction boundary");

	// a high routine is never interrupted
	AST_HI_NEVER_PREEMPTED: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_call_o |-> !$past(in_service_o[1]))
		else $error("vector call during a high level routine");

	// under a low routine only a high request may get in
	AST_LO_WAITS: assert property (@(posedge clk_i) disable iff (rst_i)
		(vec_call_o && $past(in_service_o[0])) |-> in_service_o[1])
		else $error("low level request preempted a low routine");

	// a return under a nested pair ends only the high level
	AST_RETURN_FROM_IRQ_INSTR_TOP: assert property (@(posedge clk_i) disable iff (rst_i)
		(return_from_irq_instr_end_i && in_service_o[1])
		|=> (!in_service_o[1] && (in_service_o[0] == $past(in_service_o[0]))))
		else $error("return did not end the high level alone");

	// a return under a lone low routine leaves nothing in service
	AST_RETURN_FROM_IRQ_INSTR_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
		(return_from_irq_instr_end_i && (in_service_o == 2'b01)) |=> (in_service_o == 2'b00))
		else $error("return did not end the low level");

endmodule // tvi_irq_handler

// ### verification/tvi_cpu_model.sv
// cpu sequencer model: instruction boundaries and returns
`timescale 1ns/1ns
module tvi_cpu_model
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bench control and handler call
	input wire logic [3:0] gap_i,
	input wire logic return_from_irq_instr_i,
	input wire logic vec_call_i,
	// instruction boundaries
	output logic instr_end_o,
	output logic return_from_irq_instr_end_o
);
	typedef struct packed {logic [3:0] cnt; logic pend;} tvi_cpu_s;
	tvi_cpu_s q_r;
	tvi_cpu_s q_nxt;
	// a return lands on the next boundary; gap_i makes slow instructions
	always_comb
	begin
		q_nxt = q_r;
		if (return_from_irq_instr_i)
			q_nxt.pend = 1'b1;
		else if (q_r.cnt == 4'h0)
			q_nxt.pend = 1'b0;
		if (vec_call_i)
			q_nxt.cnt = 4'h4;
		else if (q_r.cnt == 4'h0)
			q_nxt.cnt = gap_i;
		else
			q_nxt.cnt = q_r.cnt - 4'h1;
	end
	// boundaries straight from state, so a return always ends one instruction
	assign instr_end_o = (q_r.cnt == 4'h0);
	assign return_from_irq_instr_end_o = instr_end_o && q_r.pend;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			q_r <= '0;
		else
			q_r <= q_nxt;
	end
endmodule // tvi_cpu_model

// ### verification/tvi_irq_handler_test.sv
// self-checking bench for the two-level vectored interrupt handler
`timescale 1ns/1ns
`include "tvi_defs.svh"
module tvi_irq_handler_test;
	logic clk_i;
	logic rst_i = 1'b1;
	logic cs = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = '0;
	logic [31:0] rd;
	logic [`TVI_NSRC-1:0] ea = '0;
	logic [`TVI_NSRC-1:0] eb = '0;
	logic vdd = 1'b0;
	logic vbat = 1'b0;
	logic [3:0] lanes = 4'hf;
	logic [3:0] sel = 4'hf;
	logic [3:0] gap = 4'h3;
	logic rt = 1'b0;
	logic ie, re, ack, irq, vc;
	logic [31:0] dq;
	logic [15:0] va;
	logic [1:0] ins;
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;
	// rows: source order number beside its vector
	logic [20:0] rows [6] = '{{5'd0, 16'h0003}, {5'd1, 16'h000b}, {5'd7, 16'h003b},
		{5'd10, 16'h0053}, {5'd14, 16'h0073}, {5'd22, 16'h00b3}};
	tvi_irq_handler tvi_irq_handler_inst
	(
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cs), .wb_stb_i(cs), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dq), .wb_ack_o(ack),
		.src_evt_a_i(ea), .src_evt_b_i(eb), .warn_vdd_i(vdd), .warn_vbat_i(vbat),
		.instr_end_i(ie), .return_from_irq_instr_end_i(re), .irq_req_o(irq), .vec_call_o(vc),
		.vec_addr_o(va), .in_service_o(ins)
	);
	tvi_cpu_model tvi_cpu_model_inst
	(
		.clk_i(clk_i), .rst_i(rst_i), .gap_i(gap), .return_from_irq_instr_i(rt), .vec_call_i(vc),
		.instr_end_o(ie), .return_from_irq_instr_end_o(re)
	);
	// ****************
	// helpers
	// ****************
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			mismatches++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic results;
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// request held until the rising edge that sees ack, read data taken there
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cs <= 1'b1;
		we <= w;
		adr <= a;
		sel <= lanes;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = dq;
		cs <= 1'b0;
	endtask
	task automatic evt(input logic [22:0] a, input logic [22:0] b);
		@(posedge clk_i);
		ea <= a;
		eb <= b;
		@(posedge clk_i);
		ea <= '0;
		eb <= '0;
	endtask
	task automatic wait_call(input logic [15:0] v, input logic [1:0] s);
		do @(negedge clk_i); while (vc !== 1'b1);
		check(va, v);
		check(ins, s);
	endtask
	task automatic ret(input logic [1:0] s);
		@(posedge clk_i);
		rt <= 1'b1;
		@(posedge clk_i);
		rt <= 1'b0;
		do @(negedge clk_i); while (re !== 1'b1);
		@(negedge clk_i);
		check(ins, s);
	endtask
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// watchdog: cut a hang short
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			mismatches++;
			results();
		end
	end
	// ****************
	// stimulus
	// ****************
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		check(va, 16'h0000);
		check(vc, 0);
		check(irq, 0);
		check(ins, 2'b00);
		wb(1'b0, 8'h08, 0);
		check(rd, 0);
		wb(1'b1, 8'h00, 32'hff);
		wb(1'b1, 8'h04, 32'hffff);
		wb(1'b1, 8'h40, 32'hffffffff);
		wb(1'b0, 8'h04, 0);
		check(rd, 32'hffff);
		// one byte lane only: the upper enables clear, the lower ones stay
		lanes = 4'h2;
		wb(1'b1, 8'h04, 32'h0);
		lanes = 4'hf;
		wb(1'b0, 8'h04, 0);
		check(rd, 32'h00ff);
		wb(1'b1, 8'h04, 32'hffff);
		foreach (rows[i])
		begin
			evt(23'h1 << rows[i][20:16], '0);
			wait_call(rows[i][15:0], 2'b01);
			wb(1'b1, 8'h0c, 0);
			ret(2'b00);
		end
		// fastest response with a boundary every cycle
		gap <= 4'h0;
		evt(23'h8, '0);
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		check(vc, 1);
		check(va, 16'h001b);
		ret(2'b00);
		gap <= 4'h3;
		// global enable off holds the request back
		wb(1'b1, 8'h00, 32'h7f);
		evt(23'h4, '0);
		repeat (20) @(negedge clk_i);
		check(irq, 0);
		wb(1'b1, 8'h00, 32'hff);
		wait_call(16'h0013, 2'b01);
		wb(1'b0, 8'h0c, 0);
		check(rd, 0);
		ret(2'b00);
		// same-cycle requests, high wins, uncleared flag comes back
		wb(1'b1, 8'h08, 32'h20);
		evt(23'h24, '0);
		wait_call(16'h002b, 2'b10);
		ret(2'b00);
		wait_call(16'h002b, 2'b10);
		wb(1'b1, 8'h0c, 32'h4);
		ret(2'b00);
		wait_call(16'h0013, 2'b01);
		ret(2'b00);
		// second flag of a source, then a high preemption
		evt('0, 23'h10);
		wait_call(16'h0023, 2'b01);
		evt(23'h20, '0);
		wait_call(16'h002b, 2'b11);
		// status in the call: both levels in service, busy, no request
		wb(1'b0, 8'h14, 0);
		check(rd, 32'h7);
		wb(1'b1, 8'h0c, 0);
		wb(1'b1, 8'h10, 0);
		ret(2'b01);
		ret(2'b00);
		// software sets a flag
		wb(1'b1, 8'h0c, 32'h80);
		wait_call(16'h003b, 2'b01);
		wb(1'b1, 8'h0c, 0);
		ret(2'b00);
		// supply warning flag cannot be cleared, only masked
		@(posedge clk_i);
		vdd <= 1'b1;
		vbat <= 1'b1;
		wait_call(16'h007b, 2'b01);
		wb(1'b1, 8'h0c, 0);
		wb(1'b0, 8'h0c, 0);
		check(rd[15], 1);
		wb(1'b1, 8'h10, 0);
		wb(1'b0, 8'h10, 0);
		check(rd[15], 1);
		wb(1'b1, 8'h04, 32'hfeff);
		ret(2'b00);
		repeat (20) @(negedge clk_i);
		check(irq, 0);
		// reset in mid-run: last vector and the enables go back to zero
		@(posedge clk_i);
		vdd <= 1'b0;
		vbat <= 1'b0;
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		check(va, 16'h0000);
		check(ins, 2'b00);
		check(irq, 0);
		wb(1'b0, 8'h04, 0);
		check(rd, 0);
		results();
	end
endmodule // tvi_irq_handler_test
